// [logic/ppe_top.sv]
// pad ownership selector for the parallel master port, with apb register access
`timescale 1ns/1ps
`include "ppe_map.svh"

module ppe_top (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire ppe_pkg::ppe_port_drive_t port_drive,
	input  wire logic [15:0]              gpio_out,
	output ppe_pkg::ppe_pad_t             pad
);
	logic [31:0]       pin_enable_r;
	logic [31:0]       ctrl_r;
	logic [31:0]       rdata_nxt;
	logic              hit_nxt;
	logic              access;
	logic [1:0]        chip_select_function;
	logic [1:0]        address_data_mux_mode;
	ppe_pkg::ppe_pad_t pad_nxt;

	assign access                = psel && penable && pready;
	assign chip_select_function  = ctrl_r[`PPE_CS_FUNC_LSB +: 2];
	assign address_data_mux_mode = ctrl_r[`PPE_MUX_MODE_LSB +: 2];

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		hit_nxt   = 1'b1;
		if (paddr == `PPE_OFF_PIN_ENABLE) begin
			rdata_nxt = pin_enable_r;
		end else if (paddr == `PPE_OFF_PORT_CONTROL) begin
			rdata_nxt = ctrl_r;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	// answer one cycle after setup: every access completes with no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
			pslverr <= psel && !penable && !hit_nxt;
		end
	end

	// unimplemented positions are masked so they never store and read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_enable_r <= `PPE_PIN_ENABLE_RESET;
		end else if (access && pwrite && paddr == `PPE_OFF_PIN_ENABLE) begin
			pin_enable_r <= pwdata & `PPE_PIN_ENABLE_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `PPE_CTRL_RESET;
		end else if (access && pwrite && paddr == `PPE_OFF_PORT_CONTROL) begin
			ctrl_r <= pwdata & `PPE_CTRL_MASK;
		end
	end

	always_comb begin
		pad_nxt.owned = pin_enable_r[15:0];
		for (int i = 0; i < 16; i++) begin
			pad_nxt.value[i] = pin_enable_r[i] ? port_drive.addr[i] : gpio_out[i];
		end
		if (pin_enable_r[`PPE_BIT_ADDR14]) begin
			// chip select 1 replaces address 14 only in the selecting mode
			pad_nxt.value[`PPE_BIT_ADDR14] = (chip_select_function == `PPE_CS_FUNC_CS1) ?
				port_drive.cs1 : port_drive.addr[`PPE_BIT_ADDR14];
		end
		if (address_data_mux_mode != `PPE_MUX_MODE_DEMUX) begin
			if (pin_enable_r[`PPE_BIT_ALH]) begin
				pad_nxt.value[`PPE_BIT_ALH] = port_drive.alh;
			end
			if (pin_enable_r[`PPE_BIT_ALL]) begin
				pad_nxt.value[`PPE_BIT_ALL] = port_drive.all;
			end
		end
	end

	// registered pads: ownership follows a write one edge later, glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad <= '0;
		end else begin
			pad <= pad_nxt;
		end
	end
endmodule

// [logic/ppe_map.svh]
// register offsets, field positions, reset values and masks of the pin-enable block
`ifndef PPE_MAP_SVH
`define PPE_MAP_SVH

`define PPE_OFF_PIN_ENABLE     12'h000
`define PPE_OFF_PORT_CONTROL   12'h004

`define PPE_PIN_ENABLE_MASK    32'h0000_47ff
`define PPE_PIN_ENABLE_RESET   32'h0000_0000
`define PPE_BIT_ADDR14         14
`define PPE_BIT_ALH            1
`define PPE_BIT_ALL            0

`define PPE_CTRL_MASK          32'h0000_000f
`define PPE_CTRL_RESET         32'h0000_0000
`define PPE_CS_FUNC_LSB        0
`define PPE_MUX_MODE_LSB       2

`define PPE_CS_FUNC_CS1        2'h2
`define PPE_MUX_MODE_DEMUX     2'h0

`endif

// [logic/ppe_pkg.sv]
// types shared by the pin-enable block
package ppe_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic        cs1;
		logic        alh;
		logic        all;
	} ppe_port_drive_t;

	typedef struct packed {
		logic [15:0] value;
		logic [15:0] owned;
	} ppe_pad_t;
endpackage

// [test/ppe_top_asserts.sv]
// pin-enable selector assertions
`timescale 1ns/1ps
module ppe_chk (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic [15:0]              gpio_out,
	input wire ppe_pkg::ppe_port_drive_t port_drive,
	input wire ppe_pkg::ppe_pad_t        pad
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	spare_pad_a: assert property ((pad.owned & 16'hb800) == 16'h0)
		else $error("spare pad");
	free_pad_a: assert property ($past(presetn) |->
		((pad.value ^ $past(gpio_out)) & ~pad.owned) == 16'h0) else $error("free pad");
	addr_pad_a: assert property ($past(presetn) |->
		((pad.value ^ $past(port_drive.addr)) & pad.owned & 16'h07fc) == 16'h0)
		else $error("address pad");
	owned_change_a: assert property ($changed(pad.owned) |->
		$past(psel && penable && pready && pwrite, 2)) else $error("owned change");
	ready_setup_a: assert property (psel && !penable |=> pready)
		else $error("ready late");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data idle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
bind ppe_top ppe_chk u_chk (.*);

// [test/tb.sv]
// pin-enable selector tests
`timescale 1ns/1ps
module tb;
	logic                     pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic                     pwrite = 1'h0, pready, pslverr;
	logic [11:0]              paddr = 12'h000;
	logic [31:0]              pwdata = 32'h0, prdata;
	logic [15:0]              gpio_out = 16'hffff;
	ppe_pkg::ppe_port_drive_t port_drive = '{16'h0001, 1'h1, 1'h1, 1'h0};
	ppe_pkg::ppe_pad_t        pad;
	int                       errors, n_tests, cyc;
	ppe_top dut (.*);
	initial forever #12.5 pclk = ~pclk;
	always @(posedge pclk) if (++cyc == 3000) begin errors++; end_sim(); end
	task automatic chk(input string nm, logic [32:0] e, s);
		n_tests++;
		if (s !== e) begin errors++; $display("FAIL %s exp %h got %h", nm, e, s); end
	endtask
	task automatic xf(input logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		chk("apb", e, {pslverr, prdata});
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask
	task automatic pads(input logic [31:0] e);
		@(negedge pclk) chk("pad", {1'h0, e}, {1'h0, pad});
		@(posedge pclk);
	endtask
	task automatic end_sim();
		$display("%0d checks %0d errors", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		xf(1'h0, 12'h000, 32'h0, 33'h0);
		pads(32'hffff_0000);
		xf(1'h1, 12'h000, 32'hffffffff, 33'h0);
		pads(32'hb801_47ff);
		xf(1'h0, 12'h000, 32'h0, 33'h47ff);
		for (int i = 0; i < 16; i++) begin
			xf(1'h1, 12'h004, 32'(i), 33'h0);
			pads({1'h1, i[1:0] == 2'h2, 12'he00, |i[3:2], ~|i[3:2], 16'h47ff});
		end
		xf(1'h0, 12'h008, 32'h0, 33'h100000000);
		$display("tests done");
		end_sim();
	end
endmodule
